// file: rtl/v86iv_pkg.sv
// Constants, states and flag positions for the virtual-8086 interrupt unit.
// Assumes a single core clock; included before the unit itself.
package v86iv_pkg;

    // ************************************************************
    // Flag and control bit positions, limits and masks
    // ************************************************************
    localparam int FL_IE   = 9;
    localparam int FL_NT   = 14;
    localparam int FL_IO_PRIVILEGE_LEVEL = 12;
    localparam int FL_VM   = 17;
    localparam int FL_VIE  = 19;
    localparam int FL_VIP  = 20;
    localparam int CR4_VXE = 0;

    localparam logic [1:0]  IO_PRIVILEGE_LEVEL_MAX   = 2'h3;
    localparam logic [1:0]  CPL_KERNEL = 2'h0;
    localparam logic [31:0] FLAGS_RST  = 32'h0000_0002;
    localparam logic [31:0] LOW16_MASK = 32'h0000_FFFF;
    localparam logic [3:0]  PUSH_LAST  = 4'h8;

    // ************************************************************
    // Entry sequencer states
    // ************************************************************
    typedef enum logic [4:0] {
        V86IV_IDLE  = 5'b00001,
        V86IV_PUSH  = 5'b00010,
        V86IV_ENTER = 5'b00100,
        V86IV_TSAVE = 5'b01000,
        V86IV_TLOAD = 5'b10000
    } v86iv_state_e;

endpackage : v86iv_pkg

// file: rtl/v86iv_unit.sv
// Interrupt and flag virtualisation logic for virtual-8086 mode.
// Assumes the core presents decoded ops as one-cycle pulses on clk, and that
// the pin input is asynchronous while the controller request is on clk.
`timescale 1ns/1ns
`default_nettype none
module v86iv_unit (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        maskable_pin_a,
    input  wire logic        lic_req,
    input  wire logic [7:0]  lic_vector,
    input  wire logic [7:0]  pin_vector,
    input  wire logic [31:0] control_reg_four,
    input  wire logic [1:0]  current_privilege_level,
    input  wire logic        task_gate_sel,
    input  wire logic [15:0] cur_tss_selector,
    input  wire logic [31:0] new_task_flags,
    input  wire logic        clear_maskable_pin_a_op,
    input  wire logic        set_maskable_pin_a_op,
    input  wire logic        push_flags_op,
    input  wire logic        pop_flags_op,
    input  wire logic [31:0] pop_flags_data,
    input  wire logic        maskable_pin_a_return_op,
    input  wire logic [31:0] saved_flags_image,
    input  wire logic        sw_flags_wr,
    input  wire logic [31:0] sw_flags_data,
    input  wire logic        insn_start,
    input  wire logic        real_mode,
    output logic [31:0]      flags_register,
    output logic [31:0]      push_flags_data,
    output logic             protection_fault,
    output logic             maskable_pin_a_ack,
    output logic [7:0]       maskable_pin_a_vector,
    output logic             stack_push,
    output logic [3:0]       stack_push_index,
    output logic             seg_clear,
    output logic             handler_start,
    output logic             mode32_kernel,
    output logic             tss_flags_save,
    output logic [31:0]      tss_flags_image,
    output logic             tss_link_wr,
    output logic [15:0]      tss_link_value
);

    // ************************************************************
    // Input synchronisation and decode
    // ************************************************************
    logic                 pin_s1_q, pin_s2_q;
    logic [31:0]          fl_q, fl_d;
    v86iv_pkg::v86iv_state_e st_q, st_d;
    logic [3:0]           idx_q;
    logic [7:0]           vec_q;

    function automatic logic virt_active(input logic [31:0] f, input logic [31:0] cr);
        virt_active = cr[v86iv_pkg::CR4_VXE] &&
                      (f[v86iv_pkg::FL_IO_PRIVILEGE_LEVEL +: 2] < v86iv_pkg::IO_PRIVILEGE_LEVEL_MAX);
    endfunction : virt_active

    wire vact      = virt_active(fl_q, control_reg_four) && !real_mode;
    wire irq_raw   = pin_s2_q || lic_req;
    wire irq_take  = irq_raw && fl_q[v86iv_pkg::FL_IE] &&
                     (st_q == v86iv_pkg::V86IV_IDLE);
    wire vpend     = fl_q[v86iv_pkg::FL_VIP];
    wire sti_fault = vact && set_maskable_pin_a_op && vpend;
    wire both_flt  = vact && insn_start && fl_q[v86iv_pkg::FL_VIE] && vpend;
    wire [7:0] vsel = pin_s2_q ? pin_vector : lic_vector;

    // Only the second stage is read, so a metastable first stage never reaches the decode.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= maskable_pin_a;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ************************************************************
    // Flags update
    // ************************************************************
    always_comb begin
        fl_d = fl_q;
        if (sw_flags_wr) begin
            fl_d = sw_flags_data;
        end else if (st_q == v86iv_pkg::V86IV_TLOAD) begin
            fl_d = new_task_flags;
            fl_d[v86iv_pkg::FL_VM] = 1'b0;
            fl_d[v86iv_pkg::FL_NT] = 1'b1;
        end else if (st_q == v86iv_pkg::V86IV_ENTER) begin
            fl_d[v86iv_pkg::FL_VM] = 1'b0;
        end else if (maskable_pin_a_return_op) begin
            fl_d = saved_flags_image;
            if (current_privilege_level != v86iv_pkg::CPL_KERNEL) begin
                fl_d[v86iv_pkg::FL_VM] = fl_q[v86iv_pkg::FL_VM];
            end
        end else if (vact) begin
            if (clear_maskable_pin_a_op) begin
                fl_d[v86iv_pkg::FL_VIE] = 1'b0;
            end else if (set_maskable_pin_a_op && !vpend) begin
                fl_d[v86iv_pkg::FL_VIE] = 1'b1;
            end else if (pop_flags_op) begin
                fl_d[v86iv_pkg::FL_VIE] = pop_flags_data[v86iv_pkg::FL_IE];
            end
        end else if (!real_mode) begin
            if (clear_maskable_pin_a_op) begin
                fl_d[v86iv_pkg::FL_IE] = 1'b0;
            end else if (set_maskable_pin_a_op) begin
                fl_d[v86iv_pkg::FL_IE] = 1'b1;
            end else if (pop_flags_op) begin
                fl_d[v86iv_pkg::FL_IE] = pop_flags_data[v86iv_pkg::FL_IE];
            end
        end
    end

    // ************************************************************
    // Entry sequencer
    // ************************************************************
    // A task gate takes the save/load path; other vectors push nine words.
    always_comb begin
        st_d = st_q;
        case (st_q)
            v86iv_pkg::V86IV_IDLE: begin
                if (irq_take) begin
                    st_d = task_gate_sel ? v86iv_pkg::V86IV_TSAVE : v86iv_pkg::V86IV_PUSH;
                end
            end
            v86iv_pkg::V86IV_PUSH: begin
                if (idx_q == v86iv_pkg::PUSH_LAST) begin
                    st_d = v86iv_pkg::V86IV_ENTER;
                end
            end
            v86iv_pkg::V86IV_TSAVE: st_d = v86iv_pkg::V86IV_TLOAD;
            v86iv_pkg::V86IV_ENTER: st_d = v86iv_pkg::V86IV_IDLE;
            v86iv_pkg::V86IV_TLOAD: st_d = v86iv_pkg::V86IV_IDLE;
            default:                st_d = v86iv_pkg::V86IV_IDLE;
        endcase
    end

    // ************************************************************
    // State registers
    // ************************************************************
    wire       in_push  = (st_q == v86iv_pkg::V86IV_PUSH);
    wire       in_enter = (st_q == v86iv_pkg::V86IV_ENTER);
    wire       in_tsave = (st_q == v86iv_pkg::V86IV_TSAVE);
    wire       in_tload = (st_q == v86iv_pkg::V86IV_TLOAD);
    wire [3:0] idx_d    = in_push ? idx_q + 4'h1 : 4'h0;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fl_q <= v86iv_pkg::FLAGS_RST;
        end else begin
            fl_q <= fl_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q <= v86iv_pkg::V86IV_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // The index runs only while pushing, so every entry starts again at word zero.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            idx_q <= 4'h0;
        end else begin
            idx_q <= idx_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            vec_q <= 8'h00;
        end else if (irq_take) begin
            vec_q <= vsel;
        end
    end

    // ************************************************************
    // Registered outputs
    // ************************************************************
    // Every output is a flop so the core sees clean, glitch-free strobes.
    wire [31:0] push_img = vact ? {fl_q[31:v86iv_pkg::FL_IE+1], fl_q[v86iv_pkg::FL_VIE],
                                   fl_q[v86iv_pkg::FL_IE-1:0]} : fl_q;
    wire [31:0] tss_img  = fl_q | (32'h1 << v86iv_pkg::FL_VM);
    wire        fault_d  = sti_fault || both_flt;
    wire        start_d  = in_enter || in_tload;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flags_register <= v86iv_pkg::FLAGS_RST;
        end else begin
            flags_register <= fl_d;
        end
    end

    // The pushed image holds until the next push, so the core may fetch it late.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            push_flags_data <= 32'h0000_0000;
        end else if (push_flags_op) begin
            push_flags_data <= push_img;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            protection_fault <= 1'b0;
        end else begin
            protection_fault <= fault_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            maskable_pin_a_ack <= 1'b0;
        end else begin
            maskable_pin_a_ack <= irq_take;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            maskable_pin_a_vector <= 8'h00;
        end else begin
            maskable_pin_a_vector <= irq_take ? vsel : vec_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stack_push       <= 1'b0;
            stack_push_index <= 4'h0;
        end else begin
            stack_push       <= in_push;
            stack_push_index <= idx_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            seg_clear <= 1'b0;
        end else begin
            seg_clear <= in_enter;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            handler_start <= 1'b0;
        end else begin
            handler_start <= start_d;
        end
    end

    // The kernel level stands until a return; nested entries are not counted.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode32_kernel <= 1'b0;
        end else if (irq_take && !task_gate_sel) begin
            mode32_kernel <= 1'b1;
        end else if (maskable_pin_a_return_op) begin
            mode32_kernel <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tss_flags_save  <= 1'b0;
            tss_flags_image <= 32'h0000_0000;
        end else begin
            tss_flags_save  <= in_tsave;
            tss_flags_image <= tss_img;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tss_link_wr    <= 1'b0;
            tss_link_value <= 16'h0000;
        end else begin
            tss_link_wr    <= in_tsave;
            tss_link_value <= cur_tss_selector;
        end
    end

endmodule : v86iv_unit
`default_nettype wire

// file: tb/v86iv_asserts.sv
// Port-level assertions for the virtual-8086 interrupt unit.
// Assumes it is bound to v86iv_unit with every port connected by name.
`timescale 1ns/1ns
`default_nettype none
module v86iv_asserts (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [31:0] control_reg_four,
    input wire logic [1:0]  current_privilege_level,
    input wire logic        task_gate_sel,
    input wire logic [15:0] cur_tss_selector,
    input wire logic        clear_maskable_pin_a_op,
    input wire logic        set_maskable_pin_a_op,
    input wire logic        maskable_pin_a_return_op,
    input wire logic        sw_flags_wr,
    input wire logic        insn_start,
    input wire logic        real_mode,
    input wire logic [31:0] flags_register,
    input wire logic        protection_fault,
    input wire logic        maskable_pin_a_ack,
    input wire logic        stack_push,
    input wire logic        seg_clear,
    input wire logic        handler_start,
    input wire logic        tss_flags_save,
    input wire logic [31:0] tss_flags_image,
    input wire logic        tss_link_wr,
    input wire logic [15:0] tss_link_value
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire act = control_reg_four[0] && flags_register[13:12] != 2'h3 && !real_mode;

    a_ack_if_set: assert property (maskable_pin_a_ack |-> $past(flags_register[9]))
        else $error("interrupt taken while enable was clear");
    a_gate_entry: assert property (maskable_pin_a_ack && !$past(task_gate_sel) |=> stack_push [*8]
        ##1 stack_push ##1 (seg_clear && handler_start && !flags_register[17])) else $error("bad entry");
    a_task_entry: assert property (maskable_pin_a_ack && $past(task_gate_sel) |=> tss_flags_save
        && tss_link_wr && tss_flags_image[17] && tss_link_value == cur_tss_selector
        ##1 handler_start && flags_register[14] && !flags_register[17]) else $error("bad task switch");
    a_ret_cpl: assert property (maskable_pin_a_return_op && current_privilege_level != 2'h0
        |=> $stable(flags_register[17])) else $error("mode changed above level 0");
    a_cli_virt: assert property (clear_maskable_pin_a_op && act
        |=> !flags_register[19] && $stable(flags_register[9])) else $error("bad virtual clear");
    a_sti_fault: assert property (set_maskable_pin_a_op && act && flags_register[20]
        |-> ##1 $stable(flags_register[19]) ##[0:1] protection_fault) else $error("no set fault");
    a_pend_fault: assert property (insn_start && act && flags_register[20:19] == 2'h3
        |-> ##[1:2] protection_fault) else $error("no pending fault");
    a_pend_hold: assert property ($changed(flags_register[20]) |-> $past(sw_flags_wr
        || maskable_pin_a_return_op || tss_flags_save || handler_start)) else $error("pending changed");
    c_entry: cover property (maskable_pin_a_ack ##1 stack_push);
    c_task: cover property (tss_link_wr);
    c_fault: cover property (protection_fault);
endmodule : v86iv_asserts
`default_nettype wire

// file: tb/v86iv_source.sv
// Maskable interrupt source on the local controller side.
// Assumes the unit acknowledges each request with a one-cycle pulse.
`timescale 1ns/1ns
`default_nettype none
module v86iv_source (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       fire,
    input  wire logic [7:0] vec,
    input  wire logic       maskable_pin_a_ack,
    output logic            lic_req,
    output logic [7:0]      lic_vector
);
    // The request stays up until taken; a released vector shows its inverse so a late
    // sample cannot match by luck.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lic_req    <= 1'b0;
            lic_vector <= 8'h00;
        end else if (maskable_pin_a_ack) begin
            lic_req    <= 1'b0;
            lic_vector <= ~lic_vector;
        end else if (fire && !lic_req) begin
            lic_req    <= 1'b1;
            lic_vector <= vec;
        end
    end
endmodule : v86iv_source
`default_nettype wire

// file: tb/test_v86iv_unit.sv
// Self-checking bench for the virtual-8086 interrupt unit.
// Assumes the package, unit, source model and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_v86iv_unit;
    logic        clk = 1'b0, rst_b = 1'b0, task_gate_sel = 1'b0, real_mode = 1'b0;
    logic        pin = 1'b0, mode32_kernel;
    logic [3:0]  stack_push_index, last_idx = 4'h0;
    logic [7:0]  opv = 8'h00;
    logic [31:0] dat = 32'h0000_0002, control_reg_four = 32'h0000_0000;
    logic [1:0]  current_privilege_level = 2'h0;
    logic        lic_req, protection_fault, maskable_pin_a_ack, stack_push, seg_clear, handler_start;
    logic        tss_flags_save, tss_link_wr;
    logic [7:0]  lic_vector, maskable_pin_a_vector;
    logic [15:0] tss_link_value;
    logic [31:0] flags_register, push_flags_data, tss_flags_image;
    int          fails = 0, total_checks = 0, cyc = 0;
    wire  [4:0]  sig = {tss_link_wr, handler_start, stack_push, maskable_pin_a_ack, protection_fault};
    localparam logic [31:0] vf_mask = 32'h0018_0200;

    v86iv_unit i_v86iv_unit (.*, .maskable_pin_a(pin), .pin_vector(8'hA5),
        .cur_tss_selector(16'h1234), .new_task_flags(32'h0000_0002),
        .clear_maskable_pin_a_op(opv[0]), .set_maskable_pin_a_op(opv[1]), .push_flags_op(opv[2]),
        .pop_flags_op(opv[3]), .maskable_pin_a_return_op(opv[4]), .sw_flags_wr(opv[5]),
        .insn_start(opv[6]), .pop_flags_data(dat), .saved_flags_image(dat),
        .sw_flags_data(dat));
    v86iv_source i_v86iv_source (.*, .fire(opv[7]), .vec(dat[7:0]));

    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        if (stack_push) begin
            last_idx <= stack_push_index;
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One-cycle strobe of op k; the strobe is held across exactly one rising edge.
    task automatic op(input int k, input logic [31:0] d);
        @(negedge clk);
        dat = d;
        opv = 8'h01 << k;
        @(negedge clk);
        opv = 8'h00;
    endtask : op
    task automatic cnt(input int w, input int s, input logic [31:0] e, input string nm);
        logic [31:0] h;
        h = 32'h0;
        // Sampled at falling edges, so a pulse launched just before the call is counted.
        repeat (w) begin
            h = h + sig[s];
            @(negedge clk);
        end
        chk(nm, e, h);
    endtask : cnt
    task automatic hunt(input int s);
        for (int i = 0; i < 8 && sig[s] !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
    endtask : hunt
    task automatic stop_test();
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    task automatic t_flags();
        control_reg_four = 32'h0000_0001;
        op(5, 32'h0008_0202);
        op(0, 32'h0);
        chk("cli", 32'h0000_0200, flags_register & vf_mask);
        op(1, 32'h0);
        chk("sti", 32'h0008_0200, flags_register & vf_mask);
        op(2, 32'h0);
        chk("push", 32'h0000_0200, push_flags_data & 32'h0000_0200);
        op(3, 32'h0);
        chk("pop", 32'h0000_0200, flags_register & vf_mask);
        real_mode = 1'b1;
        op(1, 32'h0);
        chk("real", 32'h0000_0200, flags_register & vf_mask);
        real_mode = 1'b0;
        op(5, 32'h0000_3202);
        op(0, 32'h0);
        chk("iopl3", 32'h0000_0000, flags_register & vf_mask);
        op(5, 32'h0010_0202);
        op(1, 32'h0);
        cnt(3, 0, 32'h1, "stifault");
        chk("stikeep", 32'h0010_0200, flags_register & vf_mask);
        op(5, 32'h0018_0202);
        op(6, 32'h0);
        cnt(3, 0, 32'h1, "pendfault");
        op(5, 32'h0008_0202);
        op(6, 32'h0);
        cnt(3, 0, 32'h0, "nofault");
    endtask : t_flags
    task automatic t_ret();
        op(5, 32'h0000_4002);
        current_privilege_level = 2'h3;
        op(4, 32'h0002_0002);
        chk("ret3", 32'h0, flags_register & 32'h0002_0000);
        current_privilege_level = 2'h0;
        op(4, 32'h0002_0002);
        chk("ret0", 32'h0002_0000, flags_register & 32'h0002_0000);
        op(5, 32'h0002_0000 | (32'hFFFF_0A02 & v86iv_pkg::LOW16_MASK));
        chk("low16", 32'h0002_0A02, flags_register);
    endtask : t_ret
    task automatic t_irq();
        op(5, 32'h0002_0002);
        op(7, 32'h0000_00FF);
        cnt(20, 1, 32'h0, "masked");
        op(5, 32'h0002_0202);
        hunt(1);
        chk("vector", 32'h0000_00FF, {24'h0, maskable_pin_a_vector});
        cnt(12, 2, 32'h9, "pushes");
        chk("vmclr", 32'h0, flags_register & 32'h0002_0000);
        chk("lastidx", 32'h0000_0008, {28'h0, last_idx});
        chk("kernel", 32'h0000_0001, {31'h0, mode32_kernel});
    endtask : t_irq
    task automatic t_task();
        task_gate_sel = 1'b1;
        op(5, 32'h0002_0202);
        op(7, 32'h0);
        hunt(4);
        chk("link", 32'h0000_1234, {16'h0, tss_link_value});
        chk("saved", 32'h0002_0000, tss_flags_image & 32'h0002_0000);
        cnt(3, 3, 32'h1, "start");
        chk("loaded", 32'h0000_4000, flags_register & 32'h0002_4200);
    endtask : t_task
    task automatic t_pin();
        task_gate_sel = 1'b0;
        op(5, 32'h0002_0202);
        pin = 1'b1;
        hunt(1);
        chk("pinvec", 32'h0000_00A5, {24'h0, maskable_pin_a_vector});
        @(negedge clk);
        pin = 1'b0;
        cnt(12, 2, 32'h9, "pinpush");
    endtask : t_pin

    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        chk("reset", 32'h0000_0002, flags_register);
        t_flags();
        t_ret();
        t_irq();
        t_task();
        t_pin();
        stop_test();
    end
endmodule : test_v86iv_unit
bind v86iv_unit v86iv_asserts i_v86iv_asserts (.*);
`default_nettype wire
